/* common/prot_sw_pkg.sv */
// Summary of operation
// - traffic selection moves between working and protection lines automatically, either direction
// - working signal fail (los, lof, ais, ber over fail limit) selects protection
// - working ber over the degrade limit also selects protection
// - automatic move to protection only from working and only if protection is clean
// - revertive mode returns to working once the hold interval fully elapses
// - revert only while working stays free of fail and degrade
// - revertive defaults on for one-for-one, off for one-plus-one
// - annex b accepts only bidirectional non-revertive configuration, refuses others
// - annex b ignores manual switch requests
// - normally working line active, protection line standby
// - both ends coordinate via in-band request signalling on the lines
// - last manual request per pair is kept and readable
// - one-plus-one sends identical payload on both lines
// - establishing protection selects the working line
//
// Purpose: constants and types shared by the line protection selector.
// Assumes: 50 MHz system clock, register offsets are byte addresses.
// Notes:   hold interval counts in millisecond ticks.
package prot_sw_pkg;
   localparam int          ADDR_W         = 5;
   localparam int          DATA_W         = 32;
   localparam int          BER_W          = 16;
   localparam int          HOLD_W         = 16;

   localparam logic [4:0]  REG_CTRL       = 5'h00;
   localparam logic [4:0]  REG_MANUAL     = 5'h04;
   localparam logic [4:0]  REG_HOLD       = 5'h08;
   localparam logic [4:0]  REG_STATUS     = 5'h0C;
   localparam logic [4:0]  REG_EVENT      = 5'h10;
   localparam logic [4:0]  REG_MASK       = 5'h14;
   localparam logic [4:0]  REG_FAIL_TH    = 5'h18;
   localparam logic [4:0]  REG_DEGR_TH    = 5'h1C;

   localparam logic [1:0]  ARCH_1P1       = 2'h0;
   localparam logic [1:0]  ARCH_1T1       = 2'h1;
   localparam logic [1:0]  ARCH_ANNEXB    = 2'h2;

   localparam logic [1:0]  MAN_NONE       = 2'h0;
   localparam logic [1:0]  MAN_WORK       = 2'h1;
   localparam logic [1:0]  MAN_PROT       = 2'h2;

   localparam int          EVT_SWITCH     = 0;
   localparam int          EVT_CFG_REJ    = 1;
   localparam int          EVT_MAN_REJ    = 2;
   localparam int          EVT_W          = 3;

   localparam int          ST_ACTIVE      = 0;
   localparam int          ST_W_FAIL      = 1;
   localparam int          ST_W_DEGR      = 2;
   localparam int          ST_P_FAIL      = 3;
   localparam int          ST_P_DEGR      = 4;
   localparam int          ST_HOLDING     = 5;
   localparam int          ST_FAR_REQ     = 6;
   localparam int          STAT_W         = 7;

   localparam logic [4:0]  CTRL_RST       = 5'h00;
   localparam logic [15:0] HOLD_RST       = 16'h012C;
   localparam logic [15:0] FAIL_TH_RST    = 16'h0800;
   localparam logic [15:0] DEGR_TH_RST    = 16'h0100;
   localparam logic [2:0]  MASK_RST       = 3'h0;

   localparam int          CLK_PERIOD_NS  = 20;
   localparam int          TICK_PERIOD_NS = 1000000;
   localparam int          TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic             en;
      logic             bidir;
      logic             revert;
      logic [1:0]       arch;
   } cfg_t;

   typedef struct packed {
      logic             los;
      logic             lof;
      logic             ais;
      logic [BER_W-1:0] ber;
   } line_alarm_t;

   typedef enum logic {SEL_WORKING, SEL_PROTECT} sel_state_t;
endpackage

/* design/revert_hold_timer.sv */
// Purpose: hold interval timer for the revert decision.
// Assumes: interval in millisecond ticks from an internal divider.
// Notes:   restart has priority over run.
`timescale 1ns/1ns
`default_nettype none
module revert_hold_timer #(
   parameter int TICK_CYCLES = prot_sw_pkg::TICK_CYCLES,
   parameter int CNT_W       = prot_sw_pkg::HOLD_W
) (
   input  wire logic             clk_sys,   // system clock
   input  wire logic             rst,       // synchronous reset
   input  wire logic             restart,   // clear and hold at zero
   input  wire logic             run,       // count while high
   input  wire logic [CNT_W-1:0] interval,  // ticks to wait
   output logic                  expired,   // interval fully elapsed
   output logic                  running    // counting, not yet expired
);
   localparam int DIV_W = $clog2(TICK_CYCLES + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

   logic [DIV_W-1:0] div_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic             tick;

   assign tick    = (div_ff == DIV_LAST);
   assign expired = run && !restart && (cnt_ff >= interval);
   assign running = run && !restart && (cnt_ff < interval);

   // divider restarts with the interval so a restart never leaves a partial tick
   always_ff @(posedge clk_sys) begin
      if (rst || restart || !run) begin
         div_ff <= '0;
      end else if (tick) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + DIV_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || restart || !run) begin
         cnt_ff <= '0;
      end else if (tick && cnt_ff < interval) begin
         cnt_ff <= cnt_ff + CNT_W'(1);
      end
   end

   chk_restart_clears: assert property (@(posedge clk_sys) disable iff (rst)
      restart |=> cnt_ff == '0) else $error("hold count not cleared by restart");
endmodule
`default_nettype wire

/* design/line_protection_switch.sv */
// Purpose: selects working or protection line traffic and drives both transmit lines.
// Assumes: alarm inputs and receive data are synchronous to clk_sys.
// Notes:   register port reads return data one cycle after the read strobe.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module line_protection_switch #(
   parameter int PAY_W       = 8,
   parameter int TICK_CYCLES = prot_sw_pkg::TICK_CYCLES
) (
   input  wire logic                                 clk_sys,     // system clock
   input  wire logic                                 rst,         // synchronous reset
   input  wire logic [prot_sw_pkg::ADDR_W-1:0]       reg_addr,    // register byte address
   input  wire logic [prot_sw_pkg::DATA_W-1:0]       reg_wdata,   // write data
   input  wire logic                                 reg_wr,      // write strobe
   input  wire logic                                 reg_rd,      // read strobe
   output logic      [prot_sw_pkg::DATA_W-1:0]       reg_rdata,   // read data, cycle after strobe
   output logic                                      irq,         // unmasked event pending
   input  wire prot_sw_pkg::line_alarm_t             work_alarm,  // working line defects
   input  wire prot_sw_pkg::line_alarm_t             prot_alarm,  // protection line defects
   input  wire logic                                 far_req,     // far end in-band request
   output logic                                      near_req,    // in-band request to far end
   input  wire logic [PAY_W-1:0]                     tx_data,     // payload to transmit
   output logic      [PAY_W-1:0]                     tx_work,     // working line payload
   output logic      [PAY_W-1:0]                     tx_prot,     // protection line payload
   input  wire logic [PAY_W-1:0]                     rx_work,     // working line receive
   input  wire logic [PAY_W-1:0]                     rx_prot,     // protection line receive
   output logic      [PAY_W-1:0]                     rx_data,     // selected receive payload
   output logic                                      prot_active  // protection line selected
);
   prot_sw_pkg::cfg_t                     cfg_ff;
   prot_sw_pkg::cfg_t                     wr_cfg;
   prot_sw_pkg::cfg_t                     nxt_cfg;
   prot_sw_pkg::sel_state_t               sel_ff;
   prot_sw_pkg::sel_state_t               nxt_sel;
   logic [1:0]                            man_ff;
   logic [prot_sw_pkg::HOLD_W-1:0]        hold_ff;
   logic [prot_sw_pkg::BER_W-1:0]         fail_th_ff;
   logic [prot_sw_pkg::BER_W-1:0]         degr_th_ff;
   logic [prot_sw_pkg::EVT_W-1:0]         evt_ff;
   logic [prot_sw_pkg::EVT_W-1:0]         mask_ff;
   logic [prot_sw_pkg::EVT_W-1:0]         evt_set;
   logic [prot_sw_pkg::DATA_W-1:0]        nxt_rdata;
   logic [prot_sw_pkg::STAT_W-1:0]        status;
   logic                                  en_q_ff;
   logic                                  cfg_bad;
   logic                                  wr_ctrl;
   logic                                  wr_man;
   logic                                  rd_evt;
   logic                                  annexb;
   logic                                  man_work;
   logic                                  man_prot;
   logic                                  w_fail;
   logic                                  w_degr;
   logic                                  p_fail;
   logic                                  p_degr;
   logic                                  w_bad;
   logic                                  p_bad;
   logic                                  hold_run;
   logic                                  hold_restart;
   logic                                  hold_done;
   logic                                  hold_busy;

   function automatic logic sig_fail(input prot_sw_pkg::line_alarm_t a,
                                     input logic [prot_sw_pkg::BER_W-1:0] th);
      sig_fail = a.los || a.lof || a.ais || (a.ber > th);
   endfunction

   function automatic logic sig_degr(input prot_sw_pkg::line_alarm_t a,
                                     input logic [prot_sw_pkg::BER_W-1:0] th);
      sig_degr = (a.ber > th);
   endfunction

   assign wr_ctrl = reg_wr && (reg_addr == prot_sw_pkg::REG_CTRL);
   assign wr_man  = reg_wr && (reg_addr == prot_sw_pkg::REG_MANUAL);
   assign rd_evt  = reg_rd && (reg_addr == prot_sw_pkg::REG_EVENT);
   assign annexb  = (cfg_ff.arch == prot_sw_pkg::ARCH_ANNEXB);

   assign w_fail = sig_fail(work_alarm, fail_th_ff);
   assign w_degr = sig_degr(work_alarm, degr_th_ff);
   assign p_fail = sig_fail(prot_alarm, fail_th_ff);
   assign p_degr = sig_degr(prot_alarm, degr_th_ff);
   assign p_bad  = p_fail || p_degr;
   // a bidirectional far end asking for protection counts as a working defect here
   assign w_bad  = w_fail || w_degr || (cfg_ff.bidir && far_req);

   // stored manual request is ignored, not erased, while annex b is set
   assign man_work = !annexb && (man_ff == prot_sw_pkg::MAN_WORK);
   assign man_prot = !annexb && (man_ff == prot_sw_pkg::MAN_PROT);

   // control write: a changed architecture loads its own revertive default
   always_comb begin
      wr_cfg  = prot_sw_pkg::cfg_t'(reg_wdata[4:0]);
      nxt_cfg = wr_cfg;
      if (wr_cfg.arch != cfg_ff.arch) begin
         nxt_cfg.revert = (wr_cfg.arch == prot_sw_pkg::ARCH_1T1);
      end
      cfg_bad = (wr_cfg.arch == 2'h3) ||
                ((wr_cfg.arch == prot_sw_pkg::ARCH_ANNEXB) && (nxt_cfg.revert || !wr_cfg.bidir));
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_ff <= prot_sw_pkg::cfg_t'(prot_sw_pkg::CTRL_RST);
      end else if (wr_ctrl && !cfg_bad) begin
         cfg_ff <= nxt_cfg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         man_ff <= prot_sw_pkg::MAN_NONE;
      end else if (wr_man && !annexb) begin
         man_ff <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hold_ff    <= prot_sw_pkg::HOLD_RST;
         fail_th_ff <= prot_sw_pkg::FAIL_TH_RST;
         degr_th_ff <= prot_sw_pkg::DEGR_TH_RST;
         mask_ff    <= prot_sw_pkg::MASK_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            prot_sw_pkg::REG_HOLD:    hold_ff    <= reg_wdata[prot_sw_pkg::HOLD_W-1:0];
            prot_sw_pkg::REG_FAIL_TH: fail_th_ff <= reg_wdata[prot_sw_pkg::BER_W-1:0];
            prot_sw_pkg::REG_DEGR_TH: degr_th_ff <= reg_wdata[prot_sw_pkg::BER_W-1:0];
            prot_sw_pkg::REG_MASK:    mask_ff    <= reg_wdata[prot_sw_pkg::EVT_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_q_ff <= 1'b0;
      end else begin
         en_q_ff <= cfg_ff.en;
      end
   end

   // hold interval only counts on protection with revert armed and no manual hold
   assign hold_run     = (sel_ff == prot_sw_pkg::SEL_PROTECT) && cfg_ff.revert && !man_prot;
   assign hold_restart = w_bad;

   revert_hold_timer #(
      .TICK_CYCLES (TICK_CYCLES),
      .CNT_W       (prot_sw_pkg::HOLD_W)
   ) u_hold (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .restart  (hold_restart),
      .run      (hold_run),
      .interval (hold_ff),
      .expired  (hold_done),
      .running  (hold_busy)
   );

   // manual request moves to its target line unless that line has failed, and holds off automatic moves away from it
   always_comb begin
      nxt_sel = sel_ff;
      case (sel_ff)
         prot_sw_pkg::SEL_WORKING: begin
            if (man_prot && !p_fail) begin
               nxt_sel = prot_sw_pkg::SEL_PROTECT;
            end else if (!man_work && w_bad && !p_bad) begin
               nxt_sel = prot_sw_pkg::SEL_PROTECT;
            end
         end
         prot_sw_pkg::SEL_PROTECT: begin
            if (man_work && !w_fail) begin
               nxt_sel = prot_sw_pkg::SEL_WORKING;
            end else if (!man_prot && p_bad && !(w_fail || w_degr)) begin
               nxt_sel = prot_sw_pkg::SEL_WORKING;
            end else if (!man_prot && cfg_ff.revert && !w_bad && hold_done) begin
               nxt_sel = prot_sw_pkg::SEL_WORKING;
            end
         end
         default: nxt_sel = prot_sw_pkg::SEL_WORKING;
      endcase
      if (!cfg_ff.en || !en_q_ff) begin
         nxt_sel = prot_sw_pkg::SEL_WORKING;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sel_ff <= prot_sw_pkg::SEL_WORKING;
      end else begin
         sel_ff <= nxt_sel;
      end
   end

   // events: a set in the same cycle as the clearing read survives
   always_comb begin
      evt_set = '0;
      evt_set[prot_sw_pkg::EVT_SWITCH]  = (nxt_sel != sel_ff);
      evt_set[prot_sw_pkg::EVT_CFG_REJ] = wr_ctrl && cfg_bad;
      evt_set[prot_sw_pkg::EVT_MAN_REJ] = wr_man && annexb;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         evt_ff <= '0;
      end else if (rd_evt) begin
         evt_ff <= evt_set;
      end else begin
         evt_ff <= evt_ff | evt_set;
      end
   end

   assign irq = |(evt_ff & mask_ff);

   always_comb begin
      status = '0;
      status[prot_sw_pkg::ST_ACTIVE]  = (sel_ff == prot_sw_pkg::SEL_PROTECT);
      status[prot_sw_pkg::ST_W_FAIL]  = w_fail;
      status[prot_sw_pkg::ST_W_DEGR]  = w_degr;
      status[prot_sw_pkg::ST_P_FAIL]  = p_fail;
      status[prot_sw_pkg::ST_P_DEGR]  = p_degr;
      status[prot_sw_pkg::ST_HOLDING] = hold_busy;
      status[prot_sw_pkg::ST_FAR_REQ] = far_req;
   end

   always_comb begin
      nxt_rdata = '0;
      case (reg_addr)
         prot_sw_pkg::REG_CTRL:    nxt_rdata[4:0] = cfg_ff;
         prot_sw_pkg::REG_MANUAL:  nxt_rdata[1:0] = man_ff;
         prot_sw_pkg::REG_HOLD:    nxt_rdata[prot_sw_pkg::HOLD_W-1:0] = hold_ff;
         prot_sw_pkg::REG_STATUS:  nxt_rdata[prot_sw_pkg::STAT_W-1:0] = status;
         prot_sw_pkg::REG_EVENT:   nxt_rdata[prot_sw_pkg::EVT_W-1:0] = evt_ff;
         prot_sw_pkg::REG_MASK:    nxt_rdata[prot_sw_pkg::EVT_W-1:0] = mask_ff;
         prot_sw_pkg::REG_FAIL_TH: nxt_rdata[prot_sw_pkg::BER_W-1:0] = fail_th_ff;
         prot_sw_pkg::REG_DEGR_TH: nxt_rdata[prot_sw_pkg::BER_W-1:0] = degr_th_ff;
         default:                  nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= nxt_rdata;
      end else begin
         reg_rdata <= '0;
      end
   end

   // one-plus-one bridges permanently; one-for-one sends only on the selected line
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_work <= '0;
         tx_prot <= '0;
      end else if (cfg_ff.arch != prot_sw_pkg::ARCH_1T1) begin
         tx_work <= tx_data;
         tx_prot <= tx_data;
      end else begin
         tx_work <= (sel_ff == prot_sw_pkg::SEL_WORKING) ? tx_data : '0;
         tx_prot <= (sel_ff == prot_sw_pkg::SEL_PROTECT) ? tx_data : '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_data     <= '0;
         near_req    <= 1'b0;
         prot_active <= 1'b0;
      end else begin
         rx_data     <= (sel_ff == prot_sw_pkg::SEL_PROTECT) ? rx_prot : rx_work;
         near_req    <= (nxt_sel == prot_sw_pkg::SEL_PROTECT);
         prot_active <= (nxt_sel == prot_sw_pkg::SEL_PROTECT);
      end
   end

   chk_fail_switch: assert property (@(posedge clk_sys) disable iff (rst)
      (sel_ff == prot_sw_pkg::SEL_WORKING) && cfg_ff.en && en_q_ff && w_fail && !p_bad && !man_work
      |=> sel_ff == prot_sw_pkg::SEL_PROTECT) else $error("working fail did not select protection");

   chk_degr_switch: assert property (@(posedge clk_sys) disable iff (rst)
      (sel_ff == prot_sw_pkg::SEL_WORKING) && cfg_ff.en && en_q_ff && w_degr && !p_bad && !man_work
      |=> sel_ff == prot_sw_pkg::SEL_PROTECT) else $error("working degrade did not select protection");

   chk_prot_clean: assert property (@(posedge clk_sys) disable iff (rst)
      (sel_ff == prot_sw_pkg::SEL_WORKING) && p_bad && !man_prot
      |=> sel_ff == prot_sw_pkg::SEL_WORKING) else $error("switched onto a defective protection line");

   chk_no_early_revert: assert property (@(posedge clk_sys) disable iff (rst)
      (sel_ff == prot_sw_pkg::SEL_PROTECT) && w_bad && !man_work && !p_bad && cfg_ff.en
      |=> sel_ff == prot_sw_pkg::SEL_PROTECT) else $error("reverted while working line impaired");

   chk_annexb_cfg: assert property (@(posedge clk_sys) disable iff (rst)
      annexb |-> cfg_ff.bidir && !cfg_ff.revert) else $error("annex b holds illegal configuration");

   chk_annexb_manual: assert property (@(posedge clk_sys) disable iff (rst)
      wr_man && annexb |=> $stable(man_ff) && evt_ff[prot_sw_pkg::EVT_MAN_REJ])
      else $error("annex b manual request not refused");

   chk_establish_work: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(cfg_ff.en) |-> sel_ff == prot_sw_pkg::SEL_WORKING [*2]) else $error("not on working after establish");

   chk_switch_event: assert property (@(posedge clk_sys) disable iff (rst)
      sel_ff != $past(sel_ff) |-> evt_ff[prot_sw_pkg::EVT_SWITCH] && (prot_active == status[0]))
      else $error("line change without event or report");

   chk_bridge_equal: assert property (@(posedge clk_sys) disable iff (rst)
      (cfg_ff.arch != prot_sw_pkg::ARCH_1T1) |=> tx_work == tx_prot) else $error("bridged payloads differ");

   chk_revert_default: assert property (@(posedge clk_sys) disable iff (rst)
      wr_ctrl && !cfg_bad && (wr_cfg.arch != cfg_ff.arch)
      |=> cfg_ff.revert == (cfg_ff.arch == prot_sw_pkg::ARCH_1T1)) else $error("revertive default wrong");
endmodule
`default_nettype wire

/* testbench/far_end_model.sv */
// Purpose: far end line terminating equipment, loops payload back and raises requests.
// Assumes: both lines deliver what was sent, one cycle late.
// Notes:   request is commanded by the bench, not derived from our own request.
`timescale 1ns/1ns
`default_nettype none
module far_end_model (
   input  wire logic       clk_sys,  // system clock
   input  wire logic       req_cmd,  // bench asks for protection
   input  wire logic [7:0] tx_work,  // our working payload
   input  wire logic [7:0] tx_prot,  // our protection payload
   output logic            far_req,  // in-band request toward us
   output logic      [7:0] rx_work,  // working line receive
   output logic      [7:0] rx_prot   // protection line receive
);
   always_ff @(posedge clk_sys) begin
      rx_work <= tx_work;
      rx_prot <= tx_prot;
      far_req <= req_cmd;
   end
endmodule
`default_nettype wire

/* testbench/line_protection_switch_tb_top.sv */
// Purpose: directed scenarios for the line protection selector.
// Assumes: tick shortened to 4 clocks.
// Notes:   register port reads taken the cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module line_protection_switch_tb_top;
   logic                     clk_sys = 1'b0;
   logic                     rst = 1'b1;
   logic [4:0]               reg_addr = 5'h00;
   logic [31:0]              reg_wdata = 32'h0;
   logic                     reg_wr = 1'b0;
   logic                     reg_rd = 1'b0;
   logic [31:0]              reg_rdata;
   logic                     irq;
   prot_sw_pkg::line_alarm_t work_alarm = '0;
   prot_sw_pkg::line_alarm_t prot_alarm = '0;
   logic                     far_req;
   logic                     req_cmd = 1'b0;
   logic                     near_req;
   logic [7:0]               tx_data = 8'h00;
   logic [7:0]               tx_work;
   logic [7:0]               tx_prot;
   logic [7:0]               rx_work;
   logic [7:0]               rx_prot;
   logic [7:0]               rx_data;
   logic                     prot_active;
   int                       fail_count = 0;
   int                       compares = 0;
   logic [31:0]              d;
   always #10 clk_sys = ~clk_sys;
   line_protection_switch #(.PAY_W(8), .TICK_CYCLES(4)) dut (.clk_sys(clk_sys), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .work_alarm(work_alarm), .prot_alarm(prot_alarm),
      .far_req(far_req), .near_req(near_req), .tx_data(tx_data), .tx_work(tx_work),
      .tx_prot(tx_prot), .rx_work(rx_work), .rx_prot(rx_prot), .rx_data(rx_data),
      .prot_active(prot_active));
   far_end_model peer (.clk_sys(clk_sys), .req_cmd(req_cmd), .tx_work(tx_work),
      .tx_prot(tx_prot), .far_req(far_req), .rx_work(rx_work), .rx_prot(rx_prot));
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
         fail_count++;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      // read data stand only until this edge replaces them
      @(posedge clk_sys);
      v = reg_rdata;
   endtask
   // bounded wait for the selection to reach a line
   task automatic wait_sel(input logic v);
      int i;
      for (i = 0; i < 300 && prot_active !== v; i++) @(posedge clk_sys);
      if (prot_active !== v) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   task automatic t_reset();
      rd(prot_sw_pkg::REG_HOLD, d); chk("hold", d, 32'h0000012C);
      rd(prot_sw_pkg::REG_FAIL_TH, d); chk("fail_th", d, 32'h00000800);
      rd(prot_sw_pkg::REG_DEGR_TH, d); chk("degr_th", d, 32'h00000100);
      rd(prot_sw_pkg::REG_MASK, d); chk("mask", d, 32'h0);
      rd(5'h02, d); chk("unmapped", d, 32'h0);
      chk("sel", {31'h0, prot_active}, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_fail_revert();
      wr(prot_sw_pkg::REG_CTRL, 32'h11);
      rd(prot_sw_pkg::REG_CTRL, d); chk("ctrl", d, 32'h15);
      wr(prot_sw_pkg::REG_HOLD, 32'h3);
      wr(prot_sw_pkg::REG_MASK, 32'h1);
      rd(prot_sw_pkg::REG_EVENT, d);
      chk("normal", {30'h0, near_req, prot_active}, 32'h0);
      work_alarm.los <= 1'b1;
      wait_sel(1'b1);
      chk("near_req", {31'h0, near_req}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      rd(prot_sw_pkg::REG_EVENT, d); chk("event", d, 32'h1);
      chk("irq_clr", {31'h0, irq}, 32'h0);
      work_alarm.los <= 1'b0;
      wait_sel(1'b0);
      work_alarm.ber <= 16'h0101;
      wait_sel(1'b1);
      repeat (40) @(posedge clk_sys);
      chk("degr_hold", {31'h0, prot_active}, 32'h1);
      rd(prot_sw_pkg::REG_STATUS, d); chk("status", d, 32'h05);
      work_alarm.ber <= 16'h0100;
      wait_sel(1'b0);
      $display("fail and revert test done");
   endtask
   task automatic t_prot_bad();
      prot_alarm.lof <= 1'b1;
      work_alarm.ais <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk("no_switch", {31'h0, prot_active}, 32'h0);
      prot_alarm.lof <= 1'b0;
      work_alarm.ais <= 1'b0;
      repeat (30) @(posedge clk_sys);
      wr(prot_sw_pkg::REG_MANUAL, 32'h2);
      wait_sel(1'b1);
      rd(prot_sw_pkg::REG_MANUAL, d); chk("manual", d, 32'h2);
      wr(prot_sw_pkg::REG_MANUAL, 32'h0);
      wait_sel(1'b0);
      $display("protection alarm test done");
   endtask
   task automatic t_annexb();
      wr(prot_sw_pkg::REG_CTRL, 32'h1A);
      rd(prot_sw_pkg::REG_EVENT, d);
      req_cmd <= 1'b1;
      wait_sel(1'b1);
      wr(prot_sw_pkg::REG_MANUAL, 32'h1);
      wr(prot_sw_pkg::REG_CTRL, 32'h1E);
      wr(prot_sw_pkg::REG_CTRL, 32'h12);
      rd(prot_sw_pkg::REG_EVENT, d); chk("annexb_evt", d, 32'h7);
      rd(prot_sw_pkg::REG_CTRL, d); chk("annexb_ctrl", d, 32'h1A);
      $display("annex b test done");
   endtask
   task automatic t_payload();
      tx_data <= 8'hA5;
      repeat (4) @(posedge clk_sys);
      // one-for-one on working: the standby line carries nothing
      chk("tx_work_1t1", {24'h0, tx_work}, 32'hA5);
      chk("tx_prot_1t1", {24'h0, tx_prot}, 32'h0);
      chk("rx_data", {24'h0, rx_data}, 32'hA5);
      wr(prot_sw_pkg::REG_CTRL, 32'h10);
      rd(prot_sw_pkg::REG_CTRL, d); chk("ctrl_1p1", d, 32'h10);
      repeat (2) @(posedge clk_sys);
      chk("tx_work", {24'h0, tx_work}, 32'hA5);
      chk("tx_prot", {24'h0, tx_prot}, 32'hA5);
      $display("payload test done");
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_fail_revert();
      t_prot_bad();
      t_payload();
      t_annexb();
      report_and_stop();
   end
endmodule
`default_nettype wire
